// ### hdl/midi_router_pkg.sv
// Purpose: shared constants and types for the MIDI receive router
// Assumes: classic Wishbone register access, 32-bit data
// Notes:   selector codes: 0..127 controller, SEL_OFF, SEL_PWH, SEL_CHP
package midi_router_pkg;

   // channel modes
   typedef enum logic [1:0] {MODE_OMNI, MODE_POLY, MODE_MULTI} chan_mode_e;

   // controller source selector encoding (8 bits)
   typedef logic [7:0] srcsel_t;
   localparam srcsel_t SEL_OFF = 8'h80;
   localparam srcsel_t SEL_PWH = 8'h81;
   localparam srcsel_t SEL_CHP = 8'h82;
   localparam logic [6:0] PITCH_CC_MAX = 7'h1F;
   localparam logic [6:0] SW_CC_MIN = 7'h40;
   localparam logic [6:0] SW_CC_MAX = 7'h4F;
   localparam logic [6:0] CC_VOLUME = 7'h07;
   localparam logic [6:0] CC_PAN = 7'h0A;

   // register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_SRC0   = 8'h04;
   localparam logic [7:0] REG_SRC1   = 8'h08;
   localparam logic [7:0] REG_MAGIC  = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_LOAD   = 8'h14;
   localparam logic [7:0] REG_MAP0   = 8'h20; // 8 words, 2 presets each

   // CTRL fields
   localparam int CTRL_CHAN_LSB  = 0;  // basic channel, 4 bits
   localparam int CTRL_MODE_LSB  = 4;  // channel mode, 2 bits
   localparam int CTRL_PGM_BIT   = 6;  // receive program change
   localparam int CTRL_VPED_BIT  = 7;  // volume pedal override
   localparam int CTRL_VPAN_BIT  = 8;  // volume/pan routing
   localparam int CTRL_BOOTM_BIT = 9;  // boot multimode bit, read only in the first cycle after reset, when it is still 0
   localparam int CTRL_BSTAT_BIT = 10; // use bank state
   localparam int CTRL_DRIVE_LSB = 12; // last accessed drive, 3 bits

   // reset values
   localparam srcsel_t RST_PITCH = SEL_PWH;
   localparam srcsel_t RST_MOD   = 8'h01;
   localparam srcsel_t RST_PRESS = SEL_CHP;
   localparam srcsel_t RST_PEDAL = 8'h04;
   localparam srcsel_t RST_GENA  = 8'h05;
   localparam srcsel_t RST_GENB  = 8'h06;
   localparam srcsel_t RST_FSW1  = SEL_OFF;
   localparam srcsel_t RST_FSW2  = 8'h41;
   localparam srcsel_t RST_MAGIC = SEL_OFF;

   // decoded MIDI message from the upstream parser
   typedef struct packed {
      logic [2:0] kind; // 0 note,1 cc,2 program,3 pitch wheel,4 pressure
      logic [3:0] chan;
      logic [6:0] d1;
      logic [6:0] d2;
   } midi_msg_s;
   localparam logic [2:0] K_CC = 3'h1;
   localparam logic [2:0] K_PGM = 3'h2;
   localparam logic [2:0] K_PWH = 3'h3;
   localparam logic [2:0] K_CHP = 3'h4;

   // routed message to synthesis destinations
   typedef struct packed {
      logic [3:0] dest;   // control source id
      logic [3:0] preset; // channel slot
      logic [6:0] value;
      logic [6:0] preset_num;
   } route_s;
   localparam logic [3:0] D_PITCH = 4'h0;
   localparam logic [3:0] D_MOD   = 4'h1;
   localparam logic [3:0] D_PRESS = 4'h2;
   localparam logic [3:0] D_PEDAL = 4'h3;
   localparam logic [3:0] D_GENA  = 4'h4;
   localparam logic [3:0] D_GENB  = 4'h5;
   localparam logic [3:0] D_FSW1  = 4'h6;
   localparam logic [3:0] D_FSW2  = 4'h7;
   localparam logic [3:0] D_MVOL  = 4'h8;
   localparam logic [3:0] D_CVOL  = 4'h9;
   localparam logic [3:0] D_CPAN  = 4'hA;
   localparam logic [3:0] D_PGM   = 4'hB;
   localparam logic [3:0] D_NOTE  = 4'hC;
   localparam logic [3:0] D_RAWCC = 4'hD;

endpackage : midi_router_pkg

// ### hdl/midi_receive_router.sv
// Purpose: filter and route received MIDI messages, detect bank-load
// Assumes: upstream parser delivers one decoded message per msgValid
// Notes:   Wishbone classic slave, ack one cycle after stb, one-cycle gap
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module midi_receive_router
   import midi_router_pkg::*;
(
   // clock and reset
   input  wire  logic                      mclk,
   input  wire  logic                      rst_n,
   // wishbone slave
   input  wire  logic                      wb_cyc_i,
   input  wire  logic                      wb_stb_i,
   input  wire  logic                      wb_we_i,
   input  wire  logic [7:0]                wb_adr_i,
   input  wire  logic [3:0]                wb_sel_i,
   input  wire  logic [31:0]               wb_dat_i,
   output var   logic [31:0]               wb_dat_o,
   output var   logic                      wb_ack_o,
   // decoded midi input
   input  wire  logic                      msgValid,
   input  wire  midi_router_pkg::midi_msg_s msgIn,
   // bank state from loader: multimode bit restored on load done
   input  wire  logic                      bankLoaded,
   input  wire  logic                      bankMultiState,
   // routed output
   output var   logic                      routeValid,
   output var   midi_router_pkg::route_s   routeOut,
   output var   logic                      multiModeOn,
   output var   logic [3:0]                basicChannel,
   // bank load request
   output var   logic                      loadReq,
   output var   logic [6:0]                loadBank,
   output var   logic [2:0]                loadDrive
);
   import midi_router_pkg::*;

   logic [31:0] ctrl_q;
   srcsel_t     pitch_q, mod_q, press_q, pedal_q;
   srcsel_t     genA_q, genB_q, fsw1_q, fsw2_q, magic_q;
   logic [6:0]  presetMap_q [16];
   logic [6:0]  curPreset_q;
   logic        armed_q;
   logic        multi_q;
   logic        bootDone_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        wbReq;
   logic        wr;

   assign wbReq = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr    = wbReq & wb_we_i & wb_sel_i[0];
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   chan_mode_e modeSel;
   assign modeSel = (ctrl_q[CTRL_MODE_LSB+:2] == 2'h1) ? MODE_POLY : MODE_OMNI;
   assign basicChannel = ctrl_q[CTRL_CHAN_LSB+:4];
   assign multiModeOn  = multi_q;

   // bus ack and read data
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0;
      end else begin
         ack_q  <= wbReq;
         rdat_q <= 32'h0;
         if (wbReq && !wb_we_i) begin
            if (wb_adr_i == REG_CTRL) begin
               rdat_q <= ctrl_q;
            end else if (wb_adr_i == REG_SRC0) begin
               rdat_q <= {pedal_q, press_q, mod_q, pitch_q};
            end else if (wb_adr_i == REG_SRC1) begin
               rdat_q <= {fsw2_q, fsw1_q, genB_q, genA_q};
            end else if (wb_adr_i == REG_MAGIC) begin
               rdat_q <= {24'h0, magic_q};
            end else if (wb_adr_i == REG_STATUS) begin
               rdat_q <= {22'h0, armed_q, multi_q, 1'b0, curPreset_q};
            end else if (wb_adr_i == REG_LOAD) begin
               rdat_q <= {22'h0, loadDrive, loadBank};
            end else if (wb_adr_i[7:5] == 3'h1 && wb_adr_i[1:0] == 2'h0) begin
               rdat_q <= {9'h0, presetMap_q[{wb_adr_i[4:2], 1'b1}],
                          9'h0, presetMap_q[{wb_adr_i[4:2], 1'b0}]};
            end
         end
      end
   end

   // control register; bit 11 and bits 15 upward kept zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= 32'h0; // poly bit clear, override off
      end else if (wr && wb_adr_i == REG_CTRL) begin
         ctrl_q <= {16'h0, 1'b0, wb_dat_i[14:12], 1'b0, wb_dat_i[10:0]};
      end
   end

   // source selectors; illegal codes for pitch/mod/footswitch coerce to off
   function automatic srcsel_t legalPitch(input logic [7:0] v);
      if (v == SEL_PWH || v == SEL_CHP || v == SEL_OFF) begin
         legalPitch = v;
      end else if (!v[7] && v[6:0] <= PITCH_CC_MAX) begin
         legalPitch = v;
      end else begin
         legalPitch = SEL_OFF;
      end
   endfunction : legalPitch

   function automatic srcsel_t legalSw(input logic [7:0] v);
      if (!v[7] && v[6:0] >= SW_CC_MIN && v[6:0] <= SW_CC_MAX) begin
         legalSw = v;
      end else begin
         legalSw = SEL_OFF;
      end
   endfunction : legalSw

   function automatic srcsel_t legalCc(input logic [7:0] v);
      legalCc = v[7] ? SEL_OFF : v;
   endfunction : legalCc

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pitch_q <= RST_PITCH;
         mod_q   <= RST_MOD;
         press_q <= RST_PRESS;
         pedal_q <= RST_PEDAL;
         genA_q  <= RST_GENA;
         genB_q  <= RST_GENB;
         fsw1_q  <= RST_FSW1;
         fsw2_q  <= RST_FSW2;
         magic_q <= RST_MAGIC;
      end else if (wr) begin
         if (wb_adr_i == REG_SRC0) begin
            pitch_q <= legalPitch(wb_dat_i[7:0]);
            mod_q   <= legalPitch(wb_dat_i[15:8]);
            press_q <= (wb_dat_i[23:16] == SEL_CHP) ? SEL_CHP
                       : legalCc(wb_dat_i[23:16]);
            pedal_q <= legalCc(wb_dat_i[31:24]);
         end else if (wb_adr_i == REG_SRC1) begin
            genA_q <= legalCc(wb_dat_i[7:0]);
            genB_q <= legalCc(wb_dat_i[15:8]);
            fsw1_q <= legalSw(wb_dat_i[23:16]);
            fsw2_q <= legalSw(wb_dat_i[31:24]);
         end else if (wb_adr_i == REG_MAGIC) begin
            magic_q <= legalCc(wb_dat_i[7:0]);
         end
      end
   end

   // per-channel preset assignment for multimode
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) begin
            presetMap_q[i] <= 7'h0;
         end
      end else if (wr && wb_adr_i[7:5] == 3'h1 && wb_adr_i[1:0] == 2'h0) begin
         presetMap_q[{wb_adr_i[4:2], 1'b0}] <= wb_dat_i[6:0];
         presetMap_q[{wb_adr_i[4:2], 1'b1}] <= wb_dat_i[22:16];
      end
   end

   // multimode state: boot setting, bank restore, software toggle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         multi_q    <= 1'b0;
         bootDone_q <= 1'b0;
      end else begin
         bootDone_q <= 1'b1;
         if (!bootDone_q) begin
            multi_q <= ctrl_q[CTRL_BOOTM_BIT];
         end else if (bankLoaded && ctrl_q[CTRL_BSTAT_BIT]) begin
            multi_q <= bankMultiState;
         end else if (wr && wb_adr_i == REG_STATUS) begin
            multi_q <= wb_dat_i[8];
         end
      end
   end

   // channel filter
   logic accept;
   always_comb begin
      if (multi_q) begin
         accept = 1'b1;
      end else if (modeSel == MODE_POLY) begin
         accept = (msgIn.chan == basicChannel);
      end else begin
         accept = 1'b1;
      end
   end

   // map a message onto a selector match
   function automatic logic hit(input srcsel_t s, input midi_msg_s m);
      if (s == SEL_PWH) begin
         hit = (m.kind == K_PWH);
      end else if (s == SEL_CHP) begin
         hit = (m.kind == K_CHP);
      end else if (s[7]) begin
         hit = 1'b0;
      end else begin
         hit = (m.kind == K_CC) && (m.d1 == s[6:0]);
      end
   endfunction : hit

   logic       isPgm;
   logic       bankSeq;
   logic       fire;
   logic [3:0] dest;
   logic [6:0] val;
   logic [6:0] presetNum;
   assign isPgm = msgValid && msgIn.kind == K_PGM;

   always_comb begin
      fire = msgValid && accept;
      val  = (msgIn.kind == K_CC || msgIn.kind == K_PGM) ? msgIn.d2 : msgIn.d1;
      if (msgIn.kind == K_CC) begin
         val = msgIn.d2;
      end else if (msgIn.kind == K_PWH || msgIn.kind == K_CHP) begin
         val = msgIn.d1;
      end
      presetNum = multi_q ? presetMap_q[msgIn.chan] : curPreset_q;
      dest = D_NOTE;
      if (msgIn.kind == K_PGM) begin
         dest = D_PGM;
         val  = msgIn.d1;
         fire = fire && ctrl_q[CTRL_PGM_BIT] && !bankSeq;
      end else if (multi_q && ctrl_q[CTRL_VPAN_BIT] && msgIn.kind == K_CC
                   && msgIn.d1 == CC_VOLUME) begin
         dest = D_CVOL;
      end else if (multi_q && ctrl_q[CTRL_VPAN_BIT] && msgIn.kind == K_CC
                   && msgIn.d1 == CC_PAN) begin
         dest = D_CPAN;                         // relative pan
      end else if (hit(pedal_q, msgIn)) begin
         dest = ctrl_q[CTRL_VPED_BIT] ? D_MVOL : D_PEDAL;
      end else if (hit(pitch_q, msgIn)) begin
         dest = D_PITCH;
      end else if (hit(mod_q, msgIn)) begin
         dest = D_MOD;
      end else if (hit(press_q, msgIn)) begin
         dest = D_PRESS;
      end else if (hit(genA_q, msgIn)) begin
         dest = D_GENA;
      end else if (hit(genB_q, msgIn)) begin
         dest = D_GENB;
      end else if (hit(fsw1_q, msgIn)) begin
         dest = D_FSW1;
      end else if (hit(fsw2_q, msgIn)) begin
         dest = D_FSW2;
      end else if (msgIn.kind == K_CC) begin
         dest = D_RAWCC;                        // preset assignments
      end
   end

   // bank-load sequence: independent of filters and program switch
   assign bankSeq = isPgm && (armed_q ||
                    (!magic_q[7] && msgIn.d1 == magic_q[6:0]));

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q   <= 1'b0;
         loadReq   <= 1'b0;
         loadBank  <= 7'h0;
         loadDrive <= 3'h0;
      end else begin
         loadReq <= 1'b0;
         if (isPgm) begin
            if (armed_q) begin
               armed_q   <= 1'b0;
               loadReq   <= 1'b1;
               loadBank  <= msgIn.d1;
               loadDrive <= ctrl_q[CTRL_DRIVE_LSB+:3];
            end else if (!magic_q[7] && msgIn.d1 == magic_q[6:0]) begin
               armed_q <= 1'b1;
            end
         end
      end
   end

   // current preset follows accepted program changes outside multimode
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         curPreset_q <= 7'h0;
      end else if (fire && msgIn.kind == K_PGM && !multi_q) begin
         curPreset_q <= msgIn.d1;
      end
   end

   // routed output register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         routeValid <= 1'b0;
         routeOut   <= '0;
      end else begin
         routeValid <= fire;
         if (fire) begin
            routeOut.dest       <= dest;
            routeOut.preset     <= msgIn.chan;
            routeOut.value      <= val;
            routeOut.preset_num <= presetNum;
         end
      end
   end

endmodule : midi_receive_router
`default_nettype wire

// ### testbench/midi_receive_router_properties.sv
// Purpose: port checks for the MIDI receive router
// Assumes: control word shadowed from bus writes seen at the ports
// Notes:   bound into the router below
`timescale 1ns/100ps
`default_nettype none
module midi_router_checker (
   // clock, reset and bus
   input wire logic                       mclk,
   input wire logic                       rst_n,
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_we_i,
   input wire logic [7:0]                 wb_adr_i,
   input wire logic [31:0]                wb_dat_i,
   input wire logic                       wb_ack_o,
   // messages and results
   input wire logic                       msgValid,
   input wire midi_router_pkg::midi_msg_s msgIn,
   input wire logic                       routeValid,
   input wire midi_router_pkg::route_s    routeOut,
   input wire logic                       multiModeOn,
   input wire logic [3:0]                 basicChannel,
   input wire logic                       loadReq,
   input wire logic [6:0]                 loadBank,
   input wire logic [2:0]                 loadDrive
);
   import midi_router_pkg::*;
   logic [14:0] ctrlQ;
   logic        ctrlWr;
   // control word bits 14:0 as written, bit 11 included, latched on the ack cycle
   assign ctrlWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                   wb_adr_i == REG_CTRL;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         ctrlQ <= '0;
      else if (ctrlWr)
         ctrlQ <= wb_dat_i[14:0];
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_ack_next: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   a_route_cause: assert property (
      routeValid |-> $past(msgValid))
      else $error("route without a message");
   a_poly_drop: assert property (
      msgValid && ctrlQ[5:4] == 2'h1 && !multiModeOn &&
      msgIn.chan != basicChannel && msgIn.kind != K_PGM |=> !routeValid)
      else $error("off-channel message passed");
   a_pgm_gate: assert property (
      msgValid && msgIn.kind == K_PGM && !ctrlQ[6] |=> !routeValid)
      else $error("program passed while gated");
   a_load_cause: assert property (
      loadReq |-> $past(msgValid) && $past(msgIn.kind) == K_PGM &&
      loadBank == $past(msgIn.d1))
      else $error("load not from a program");
   a_load_drive: assert property (
      loadReq |-> loadDrive == ctrlQ[14:12])
      else $error("load on wrong drive");
   a_chan_follow: assert property (
      ctrlWr |-> ##[1:2] basicChannel == ctrlQ[3:0])
      else $error("basic channel not updated");
   a_vpan_multi: assert property (
      msgValid && msgIn.kind == K_CC && msgIn.d1 == CC_VOLUME &&
      multiModeOn && ctrlQ[8] |=> routeValid && routeOut.dest == D_CVOL)
      else $error("volume not routed to channel");
endmodule : midi_router_checker
bind midi_receive_router midi_router_checker chk (.mclk, .rst_n,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
   .msgValid, .msgIn, .routeValid, .routeOut, .multiModeOn,
   .basicChannel, .loadReq, .loadBank, .loadDrive);
`default_nettype wire

// ### testbench/midi_sender_model.sv
// Purpose: keyboard model feeding decoded messages
// Assumes: one message per call, launched at a rising edge
// Notes:   idle message lines carry inverted data, never stale
`timescale 1ns/100ps
`default_nettype none
module midi_sender_model (
   // clock
   input  wire logic                       mclk,
   // decoded message stream
   output var  logic                       msgValid,
   output var  midi_router_pkg::midi_msg_s msgIn
);
   import midi_router_pkg::*;
   // quiet lines at time zero
   initial begin
      msgValid = 1'b0;
      msgIn = '0;
   end
   // one message for one cycle
   task automatic send(input logic [2:0] k, input logic [3:0] c,
                       input logic [6:0] a, b);
      @(posedge mclk);
      msgValid <= 1'b1;
      msgIn <= '{k, c, a, b};
      @(posedge mclk);
      msgValid <= 1'b0;
      msgIn <= ~{k, c, a, b};
   endtask : send
   // trigger then bank number, no program between
   task automatic send_bank(input logic [6:0] trig, bank);
      send(K_PGM, 4'h0, trig, 7'h00);
      send(K_PGM, 4'h9, bank, 7'h00);
   endtask : send_bank
endmodule : midi_sender_model
`default_nettype wire

// ### testbench/tb.sv
// Purpose: self-checking bench for the MIDI receive router
// Assumes: bus and messages driven on rising edges
// Notes:   keyboard side played by the sender model
`timescale 1ns/100ps
`default_nettype none
module tb;
   import midi_router_pkg::*;
   logic        mclk, rst_n, req, we, ack, bankLoaded, bankMultiState;
   logic        msgValid, routeValid, multiModeOn, loadReq;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat;
   logic [3:0]  basicChannel;
   logic [6:0]  loadBank;
   logic [2:0]  loadDrive;
   midi_msg_s   msgIn;
   route_s      routeOut;
   int          failCount, samplesChecked;
   // design and keyboard model
   midi_receive_router dut (.mclk, .rst_n, .wb_cyc_i(req), .wb_stb_i(req),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .msgValid, .msgIn, .bankLoaded,
      .bankMultiState, .routeValid, .routeOut, .multiModeOn,
      .basicChannel, .loadReq, .loadBank, .loadDrive);
   midi_sender_model snd (.mclk, .msgValid, .msgIn);
   // clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic endOfTest();
      if (failCount == 0 && samplesChecked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : endOfTest
   task automatic check(input logic [31:0] got, exp);
      samplesChecked++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   // one classic bus cycle, held until ack
   task automatic wbx(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) check(32'h0, 32'h1);
      q = rdat;
      req <= 1'b0;
   endtask : wbx
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wbx(a, 1'b1, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wbx(a, 1'b0, 32'h0, q);
      check(q, e);
   endtask : rd
   // send one message, judge the routed result
   task automatic route(input logic [2:0] k, input logic [3:0] c,
      input logic [6:0] a, b, input logic ok, input logic [3:0] dst);
      snd.send(k, c, a, b);
      #1;
      check(32'(routeValid), 32'(ok));
      if (ok) begin
         check(32'({routeOut.dest, routeOut.preset}), 32'({dst, c}));
         if (k != K_PGM) check(32'(routeOut.value), 32'(k == K_CC ? b : a));
      end
   endtask : route
   task automatic t_defaults();
      rd(REG_SRC0, 32'h0482_0181);
      rd(REG_SRC1, 32'h4180_0605);
      rd(REG_MAGIC, 32'h0000_0080);
      rd(REG_CTRL, 32'h0);
      wr(8'hFC, 32'hFFFF_FFFF);
      rd(8'hFC, 32'h0);
      check(32'(multiModeOn), 32'h0);
   endtask : t_defaults
   task automatic t_poly();
      wr(REG_CTRL, 32'h13);
      repeat (2) @(posedge mclk);
      check(32'(basicChannel), 32'h3);
      route(K_CC, 4'h5, 7'h01, 7'h11, 1'b0, D_MOD);
      route(K_CC, 4'h3, 7'h01, 7'h12, 1'b1, D_MOD);
   endtask : t_poly
   task automatic t_sources();
      logic [13:0] tbl [7];
      tbl = '{{K_PWH, 7'h33, D_PITCH}, {K_CC, 7'h01, D_MOD},
              {K_CHP, 7'h33, D_PRESS}, {K_CC, 7'h04, D_PEDAL},
              {K_CC, 7'h05, D_GENA}, {K_CC, 7'h06, D_GENB},
              {K_CC, 7'h41, D_FSW2}};
      wr(REG_CTRL, 32'h0);
      for (int i = 0; i < 7; i++)
         route(tbl[i][13:11], 4'(2 * i + 1), tbl[i][10:4], 7'h2A, 1'b1,
               tbl[i][3:0]);
      wr(REG_SRC0, 32'h0482_011F);
      route(K_CC, 4'h0, 7'h1F, 7'h01, 1'b1, D_PITCH);
      wr(REG_SRC1, 32'h414F_0610);
      route(K_CC, 4'h0, 7'h10, 7'h02, 1'b1, D_GENA);
      route(K_CC, 4'h0, 7'h4F, 7'h7F, 1'b1, D_FSW1);
      wr(REG_SRC1, 32'h4120_0610);
      rd(REG_SRC1, 32'h4180_0610);
      wr(REG_SRC0, 32'h0482_0120);
      rd(REG_SRC0, 32'h0482_0180);
   endtask : t_sources
   task automatic t_program();
      route(K_PGM, 4'h2, 7'h05, 7'h00, 1'b0, D_PGM);
      wr(REG_CTRL, 32'h40);
      route(K_PGM, 4'h2, 7'h05, 7'h00, 1'b1, D_PGM);
   endtask : t_program
   task automatic t_bank();
      wr(REG_CTRL, 32'h2000);
      wr(REG_MAGIC, 32'h55);
      snd.send_bank(7'h55, 7'h0B);
      #1;
      check(32'({loadReq, loadBank, loadDrive}), 32'h45A);
      wr(REG_MAGIC, 32'h7F);
      snd.send_bank(7'h7F, 7'h00);
      #1;
      check(32'({loadReq, loadBank, loadDrive}), 32'h402);
      wr(REG_MAGIC, 32'h80);
      snd.send_bank(7'h7F, 7'h0C);
      #1;
      check(32'({loadReq, loadBank}), 32'h0);
   endtask : t_bank
   task automatic t_multi();
      wr(REG_CTRL, 32'h100);
      wr(REG_MAP0 + 8'h04, 32'h15);
      wr(REG_STATUS, 32'h100);
      repeat (2) @(posedge mclk);
      check(32'(multiModeOn), 32'h1);
      route(K_CC, 4'h2, CC_VOLUME, 7'h40, 1'b1, D_CVOL);
      check(32'(routeOut.preset_num), 32'h15);
      route(K_CC, 4'h9, CC_PAN, 7'h10, 1'b1, D_CPAN);
      wr(REG_STATUS, 32'h0);
      route(K_CC, 4'h2, CC_VOLUME, 7'h40, 1'b1, D_RAWCC);
      wr(REG_CTRL, 32'h80);
      route(K_CC, 4'h1, 7'h04, 7'h22, 1'b1, D_MVOL);
   endtask : t_multi
   task automatic t_bank_state();
      for (int i = 0; i < 2; i++) begin
         wr(REG_CTRL, i ? 32'h0 : 32'h400);
         bankMultiState <= 1'b1;
         bankLoaded <= 1'b1;
         @(posedge mclk);
         bankLoaded <= 1'b0;
         repeat (2) @(posedge mclk);
         check(32'(multiModeOn), i ? 32'h0 : 32'h1);
         wr(REG_STATUS, 32'h0);
      end
   endtask : t_bank_state
   // reset, then scenarios
   initial begin
      {rst_n, req, we, bankLoaded, bankMultiState} = '0;
      adr = 8'h00;
      wdat = 32'h0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_defaults();
      t_poly();
      t_sources();
      t_program();
      t_bank();
      t_multi();
      t_bank_state();
      endOfTest();
   end
   // hang guard
   initial begin
      #125000;
      failCount++;
      endOfTest();
   end
endmodule : tb
`default_nettype wire
